// file: hdl/key_return_interrupt.sv
// Purpose: Key-return interrupt controller with APB register access
// Assumes: pclk 200 MHz, presetn asynchronous active low
// Notes: Zero-wait APB slave; unmapped addresses answer pslverr
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module key_return_interrupt
    import key_return_pkg::*;
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire key_return_pkg::apb_req_t apb_req,
    output key_return_pkg::apb_rsp_t apb_rsp,
    // Keys and port pins
    input wire logic [key_return_pkg::NUM_KEYS-1:0] key_return_inputs,
    output key_return_pkg::pin_ctrl_t pin_ctrl,
    // Interrupt
    output logic key_interrupt,
    output logic [1:0] key_priority_level
);
    import key_return_pkg::*;

    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] flags;
        logic [7:0] masks;
        logic [7:0] prio_lo;
        logic [7:0] prio_hi;
        logic [7:0] enable_low;
        logic [7:0] enable_high;
        logic [7:0] edge_ctrl;
        logic [7:0] pullup12;
        logic [7:0] pullup0;
        logic [NUM_KEY_FLAGS-1:0] key_flags;
        apb_rsp_t rsp;
        pin_ctrl_t pins;
        logic irq;
        logic [1:0] level;
    } ctrl_state_t;

    ctrl_state_t state_reg;
    ctrl_state_t state_next;

    logic [NUM_KEYS-1:0] key_enables;
    logic [NUM_KEYS-1:0] key_level;
    logic [NUM_KEYS-1:0] key_hit;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection
    assign key_enables = {state_reg.enable_high[1:0], state_reg.enable_low};

    key_edge_detect key_edge_detect_inst (
        .pclk(pclk),
        .presetn(presetn),
        .enable(key_enables),
        .rising(state_reg.edge_ctrl[EDGE_BIT]),
        .keys_in(key_return_inputs),
        .level(key_level),
        .hit(key_hit)
    );

    function automatic logic [31:0] widen(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic wr_en;
    logic rd_en;
    logic [7:0] wd;

    always_comb begin
        state_next = state_reg;
        wr_en = apb_req.psel && !apb_req.penable && apb_req.pwrite;
        rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        wd = apb_req.pwdata[7:0];
        state_next.rsp.pready = apb_req.psel && !apb_req.penable;
        state_next.rsp.pslverr = 1'b0;
        state_next.rsp.prdata = 32'h00000000;

        if (wr_en) begin
            unique case (apb_req.paddr)
                OFS_DIRECTION: state_next.direction = wd | ~DIR_USED_MASK;
                OFS_FLAGS: state_next.flags = wd;
                OFS_MASKS: state_next.masks = wd;
                OFS_PRIO_LO: state_next.prio_lo = wd;
                OFS_PRIO_HI: state_next.prio_hi = wd;
                OFS_ENABLE_LOW: state_next.enable_low = wd;
                OFS_ENABLE_HIGH: state_next.enable_high = wd & ENABLE_HIGH_MASK;
                OFS_EDGE_CTRL: state_next.edge_ctrl = wd & EDGE_CTRL_MASK;
                OFS_PULLUP12: state_next.pullup12 = wd;
                OFS_PULLUP0: state_next.pullup0 = wd & PULLUP0_MASK;
                OFS_KEY_FLAGS: state_next.key_flags = state_reg.key_flags & wd[5:0];
                OFS_PIN_LEVEL: ;
                default: state_next.rsp.pslverr = 1'b1;
            endcase
        end

        if (rd_en) begin
            unique case (apb_req.paddr)
                OFS_DIRECTION: state_next.rsp.prdata = widen(state_reg.direction);
                OFS_FLAGS: state_next.rsp.prdata = widen(state_reg.flags);
                OFS_MASKS: state_next.rsp.prdata = widen(state_reg.masks);
                OFS_PRIO_LO: state_next.rsp.prdata = widen(state_reg.prio_lo);
                OFS_PRIO_HI: state_next.rsp.prdata = widen(state_reg.prio_hi);
                OFS_ENABLE_LOW: state_next.rsp.prdata = widen(state_reg.enable_low);
                OFS_ENABLE_HIGH: state_next.rsp.prdata = widen(state_reg.enable_high);
                OFS_EDGE_CTRL: state_next.rsp.prdata = widen(state_reg.edge_ctrl);
                OFS_PULLUP12: state_next.rsp.prdata = widen(state_reg.pullup12);
                OFS_PULLUP0: state_next.rsp.prdata = widen(state_reg.pullup0);
                OFS_KEY_FLAGS: state_next.rsp.prdata = {26'h0000000, state_reg.key_flags};
                OFS_PIN_LEVEL: state_next.rsp.prdata = {22'h000000, key_level};
                default: state_next.rsp.pslverr = 1'b1;
            endcase
        end

        // Per-input flags for keys 0 to 5 only: sticky, write 0 clears, set wins
        if (state_reg.edge_ctrl[MODE_BIT]) begin
            state_next.key_flags = state_next.key_flags
                                 | key_hit[NUM_KEY_FLAGS-1:0];
        end

        // Request flag: set wins over a same-cycle software clear
        if (|key_hit) begin
            state_next.flags[KEY_BIT] = 1'b1;
        end

        // Pin drive: direction 0 drives, 1 releases
        state_next.pins.dir_oe_n = state_next.direction[1:0];
        state_next.pins.dir_out = 2'b00;
        state_next.pins.pullup_en = {state_next.pullup0[3:0], 4'h0,
                                     state_next.pullup12[PU12_BIT], 1'b0};

        // Interrupt only while unmasked
        state_next.irq = state_next.flags[KEY_BIT]
                       && !state_next.masks[KEY_BIT];
        state_next.level = {state_next.prio_hi[KEY_BIT],
                            state_next.prio_lo[KEY_BIT]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.direction <= RST_DIRECTION;
            state_reg.flags <= RST_FLAGS;
            state_reg.masks <= RST_MASKS;
            state_reg.prio_lo <= RST_PRIO;
            state_reg.prio_hi <= RST_PRIO;
            state_reg.enable_low <= RST_ENABLE;
            state_reg.enable_high <= RST_ENABLE;
            state_reg.edge_ctrl <= RST_EDGE_CTRL;
            state_reg.pullup12 <= RST_PULLUP;
            state_reg.pullup0 <= RST_PULLUP;
            state_reg.key_flags <= '0;
            state_reg.rsp <= '0;
            state_reg.pins.dir_out <= 2'b00;
            state_reg.pins.dir_oe_n <= 2'b11;
            state_reg.pins.pullup_en <= '0;
            state_reg.irq <= 1'b0;
            state_reg.level <= 2'b11;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign apb_rsp = state_reg.rsp;
    assign pin_ctrl = state_reg.pins;
    assign key_interrupt = state_reg.irq;
    assign key_priority_level = state_reg.level;

endmodule

// file: hdl/key_return_pkg.sv
// Purpose: Constants and carrier types for the key-return interrupt block
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Register offsets are local choices; see hand-over
package key_return_pkg;

    localparam int unsigned NUM_KEYS = 10;

    // Byte offsets
    localparam logic [11:0] OFS_DIRECTION = 12'h000;
    localparam logic [11:0] OFS_FLAGS = 12'h004;
    localparam logic [11:0] OFS_MASKS = 12'h008;
    localparam logic [11:0] OFS_PRIO_LO = 12'h00C;
    localparam logic [11:0] OFS_PRIO_HI = 12'h010;
    localparam logic [11:0] OFS_ENABLE_LOW = 12'h014;
    localparam logic [11:0] OFS_ENABLE_HIGH = 12'h018;
    localparam logic [11:0] OFS_EDGE_CTRL = 12'h01C;
    localparam logic [11:0] OFS_PULLUP12 = 12'h020;
    localparam logic [11:0] OFS_PULLUP0 = 12'h024;
    localparam logic [11:0] OFS_KEY_FLAGS = 12'h028;
    localparam logic [11:0] OFS_PIN_LEVEL = 12'h02C;

    // Field positions and key-flag count
    localparam int unsigned KEY_BIT = 4;
    localparam int unsigned EDGE_BIT = 0;
    localparam int unsigned MODE_BIT = 7;
    localparam int unsigned PU12_BIT = 5;
    localparam int unsigned NUM_KEY_FLAGS = 6;

    // Reset values and write masks
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_MASKS = 8'hFF;
    localparam logic [7:0] RST_PRIO = 8'hFF;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_EDGE_CTRL = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] DIR_USED_MASK = 8'h03;
    localparam logic [7:0] ENABLE_HIGH_MASK = 8'h03;
    localparam logic [7:0] EDGE_CTRL_MASK = 8'h81;
    localparam logic [7:0] PULLUP0_MASK = 8'h0F;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [1:0] dir_out;
        logic [1:0] dir_oe_n;
        logic [NUM_KEYS-1:0] pullup_en;
    } pin_ctrl_t;

endpackage

// file: hdl/key_edge_detect.sv
// Purpose: Synchronise key inputs and flag the selected edge on enabled ones
// Assumes: Key lines are asynchronous to pclk
// Notes: Two flops before any logic reads a key line
`timescale 1ns/100ps
module key_edge_detect
    import key_return_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [NUM_KEYS-1:0] enable,
    input wire logic rising,
    // Keys
    input wire logic [NUM_KEYS-1:0] keys_in,
    output logic [NUM_KEYS-1:0] level,
    output logic [NUM_KEYS-1:0] hit
);
    typedef struct packed {
        logic [NUM_KEYS-1:0] meta;
        logic [NUM_KEYS-1:0] sync;
        logic [NUM_KEYS-1:0] prev;
    } edge_state_t;

    edge_state_t state_reg;
    edge_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.meta = keys_in;
        state_next.sync = state_reg.meta;
        state_next.prev = state_reg.sync;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{default: '1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.sync;
    // Edge per polarity, gated by per-input enable
    assign hit = enable & (rising ? (state_reg.sync & ~state_reg.prev)
                                  : (~state_reg.sync & state_reg.prev));
endmodule

// file: tb/key_return_props.sv
// Purpose: Port-level properties of the key-return interrupt block
// Assumes: Zero-wait APB slave, writes land at the setup edge
// Notes: Bound to the design top, sees its ports only
`timescale 1ns/100ps
module key_return_props
    import key_return_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire key_return_pkg::apb_req_t apb_req,
    input wire key_return_pkg::apb_rsp_t apb_rsp,
    input wire key_return_pkg::pin_ctrl_t pin_ctrl,
    input wire logic key_interrupt,
    input wire logic [1:0] key_priority_level
);
    logic setup;
    logic wr;
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = setup && apb_req.pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (setup |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready stood two cycles");
    a_rdata_upper: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_slverr_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("error flag without ready");
    a_dir_write: assert property (wr && apb_req.paddr == OFS_DIRECTION |->
        ##2 pin_ctrl.dir_oe_n == $past(apb_req.pwdata[1:0], 2))
        else $error("direction not on enables");
    a_dir_low: assert property (pin_ctrl.dir_out == 2'h0)
        else $error("pin drive value not low");
    a_prio_lo: assert property (wr && apb_req.paddr == OFS_PRIO_LO |->
        ##2 key_priority_level[0] == $past(apb_req.pwdata[4], 2))
        else $error("priority low bit wrong");
    a_prio_hi: assert property (wr && apb_req.paddr == OFS_PRIO_HI |->
        ##2 key_priority_level[1] == $past(apb_req.pwdata[4], 2))
        else $error("priority high bit wrong");
    a_mask_blocks: assert property (wr && apb_req.paddr == OFS_MASKS &&
        apb_req.pwdata[4] |-> ##1 !key_interrupt)
        else $error("masked request still raised");
    a_pullup_map: assert property (wr && apb_req.paddr == OFS_PULLUP0 |->
        ##2 pin_ctrl.pullup_en[9:6] == $past(apb_req.pwdata[3:0], 2))
        else $error("pull-up bits not mapped");
    a_pullup_none: assert property ({pin_ctrl.pullup_en[5:2], pin_ctrl.pullup_en[0]} == 5'h0)
        else $error("pull-up on key without one");
endmodule
bind key_return_interrupt key_return_props key_return_props_inst (.pclk(pclk),
    .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_ctrl(pin_ctrl),
    .key_interrupt(key_interrupt), .key_priority_level(key_priority_level));

// file: tb/key_matrix_model.sv
// Purpose: Key return lines of a matrix with pull-ups
// Assumes: A pressed key pulls its line low
// Notes: Released lines go back to the pull-up level
`timescale 1ns/100ps
module key_matrix_model (
    // Key presses
    input wire logic [9:0] pressed,
    // Return lines
    output logic [9:0] lines
);
    assign lines = ~pressed;
endmodule

// file: tb/test_key_return_interrupt.sv
// Purpose: Register and key-edge tests of the key-return block
// Assumes: 200 MHz pclk, reset held 16 cycles
// Notes: Request flag clears by writing 0 to bit 4
`timescale 1ns/100ps
module test_key_return_interrupt;
    import key_return_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic [9:0] pressed = 10'h000;
    logic [9:0] key_lines;
    pin_ctrl_t pin_ctrl;
    logic key_interrupt;
    logic [1:0] key_priority_level;
    logic [7:0] rd;
    logic err;
    int num_errors = 0;
    int n_compared = 0;
    always #2.5 pclk = ~pclk;
    key_matrix_model key_matrix_model_inst (.pressed(pressed), .lines(key_lines));
    key_return_interrupt key_return_interrupt_inst (.pclk(pclk), .presetn(presetn),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .key_return_inputs(key_lines),
        .pin_ctrl(pin_ctrl), .key_interrupt(key_interrupt),
        .key_priority_level(key_priority_level));
    ////////////////////////////////////////
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        apb_req <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: {24'h0, d}};
        @(posedge pclk);
        apb_req.penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'h1);
        rd = apb_rsp.prdata[7:0];
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        xfer(a, 1'h0, 8'h00);
        chk({2'h0, rd}, {2'h0, e});
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        wait_n(16);
        presetn <= 1'h1;
        wait_n(3);
        rchk(OFS_DIRECTION, 8'hFF);
        rchk(OFS_MASKS, 8'hFF);
        rchk(OFS_PRIO_HI, 8'hFF);
        xfer(OFS_DIRECTION, 1'h1, 8'h02);
        wait_n(2);
        chk({8'h00, pin_ctrl.dir_oe_n}, 10'h002);
        rchk(OFS_DIRECTION, 8'hFE);
        xfer(OFS_DIRECTION, 1'h1, 8'hFF);
        xfer(OFS_ENABLE_HIGH, 1'h1, 8'hFF);
        rchk(OFS_ENABLE_HIGH, 8'h03);
        xfer(OFS_EDGE_CTRL, 1'h1, 8'h7E);
        rchk(OFS_EDGE_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            xfer(OFS_PRIO_LO, 1'h1, {3'h0, i[0], 4'h0});
            xfer(OFS_PRIO_HI, 1'h1, {3'h0, i[1], 4'h0});
            wait_n(2);
            chk({8'h0, key_priority_level}, 10'(i));
        end
        xfer(OFS_PULLUP12, 1'h1, 8'hFF);
        xfer(OFS_PULLUP0, 1'h1, 8'hFF);
        wait_n(2);
        chk(pin_ctrl.pullup_en, 10'h3C2);
        xfer(OFS_FLAGS, 1'h1, 8'h00);
        xfer(OFS_MASKS, 1'h1, 8'hEF);
        xfer(OFS_PRIO_LO, 1'h1, 8'h10);
        xfer(OFS_PRIO_HI, 1'h1, 8'h10);
        xfer(OFS_ENABLE_LOW, 1'h1, 8'hFF);
        xfer(OFS_ENABLE_HIGH, 1'h1, 8'h00);
        xfer(OFS_EDGE_CTRL, 1'h1, 8'h00);
        pressed <= 10'h100;
        wait_n(8);
        chk({9'h0, key_interrupt}, 10'h000);
        rchk(OFS_FLAGS, 8'h00);
        pressed <= 10'h101;
        wait_n(6);
        chk({9'h0, key_interrupt}, 10'h001);
        rchk(OFS_FLAGS, 8'h10);
        xfer(OFS_MASKS, 1'h1, 8'hFF);
        wait_n(2);
        chk({9'h0, key_interrupt}, 10'h000);
        xfer(OFS_MASKS, 1'h1, 8'hEF);
        wait_n(2);
        chk({9'h0, key_interrupt}, 10'h001);
        xfer(OFS_FLAGS, 1'h1, 8'h00);
        wait_n(2);
        chk({9'h0, key_interrupt}, 10'h000);
        xfer(OFS_EDGE_CTRL, 1'h1, 8'h01);
        pressed <= 10'h000;
        wait_n(6);
        rchk(OFS_FLAGS, 8'h10);
        rchk(OFS_KEY_FLAGS, 8'h00);
        xfer(OFS_FLAGS, 1'h1, 8'h00);
        xfer(OFS_EDGE_CTRL, 1'h1, 8'h00);
        xfer(OFS_ENABLE_HIGH, 1'h1, 8'h02);
        pressed <= 10'h200;
        wait_n(6);
        chk({9'h0, key_interrupt}, 10'h001);
        xfer(OFS_FLAGS, 1'h1, 8'h00);
        xfer(OFS_EDGE_CTRL, 1'h1, 8'h80);
        pressed <= 10'h204;
        wait_n(6);
        rchk(OFS_KEY_FLAGS, 8'h04);
        rchk(OFS_FLAGS, 8'h10);
        xfer(OFS_KEY_FLAGS, 1'h1, 8'hFB);
        rchk(OFS_KEY_FLAGS, 8'h00);
        xfer(12'h0FC, 1'h0, 8'h00);
        chk({9'h0, err}, 10'h001);
        give_verdict();
    end
    initial begin
        #10000;
        num_errors++;
        give_verdict();
    end
endmodule
